/* core/mcu_supervisor_watchdog.sv */
// Timeout supervisor, self-test status register and driver gating.
// Assumes register writes arrive decoded on mclk_in; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Reset turns drivers off, pulls reset line low, loads register defaults
// - Self-test isolates status from fault logic
// - Self-test writes store ones and zeros
// - Otherwise host clears, faults set status
// - Leaving self-test restores status defaults
// - Supervisor reset clears self-test bit
// - Refresh reloads interval and restarts count
// - Elapsed interval pulses MCU reset low
// - Any reset restores ten seconds, enabled
// - Mantissa zero means one, above ten ten
// - Bits six, five, four pick multipliers
// - Several multiplier bits: largest wins
// - Config bit seven enables the supervisor
// - Control bit seven written one refreshes
// - Nonzero control bits give temporary interval
// - Control register clears when loaded
// - Key low forces drivers off except relay
// - Reset line low forces all drivers off
// - Pin OR/AND SPI bit per select bit
module mcu_supervisor_watchdog #(
   parameter int TICK_CYC = supervisor_pkg::TICK_CYC,
   parameter int RST_PULSE_MS = supervisor_pkg::RST_PULSE_MS
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Register port
   input wire supervisor_pkg::reg_req_t reg_req_in,
   input wire logic [2:0] reg_rd_addr_in,
   output logic [7:0] rd_data_out,
   // Pins and fault sources (asynchronous)
   input wire logic ignition_key_input_in,
   input wire logic [supervisor_pkg::NUM_DRV-1:0] drv_pin_in,
   input wire logic [7:0] fault_in,
   // Open-drain MCU reset line
   input wire logic mcu_reset_output_in,
   output logic mcu_reset_output_out,
   output logic mcu_reset_output_oe_n_out,
   // Low-side driver controls
   output logic [supervisor_pkg::NUM_DRV-1:0] low_side_driver_on_out,
   output logic [supervisor_pkg::NUM_DRV-1:0] ol_pulldown_en_out
);
   import supervisor_pkg::*;

   localparam int PW = $clog2(TICK_CYC);
   localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYC - 1);
   localparam logic [7:0] PULSE_LEN = 8'(RST_PULSE_MS);
   localparam int SW = 2 + NUM_DRV + 8;

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [SW-1:0] sync1_r; // First stage, read only by second
   logic [SW-1:0] sync2_r; // Stable copies
   wire logic key_s = sync2_r[0];
   wire logic rst_pin_s = sync2_r[1];
   wire logic [NUM_DRV-1:0] pin_s = sync2_r[2 +: NUM_DRV];
   wire logic [7:0] fault_s = sync2_r[2+NUM_DRV +: 8];

   // Two flops for every asynchronous input
   always_ff @(posedge mclk_in) begin
      sync1_r <= {fault_in, drv_pin_in, mcu_reset_output_in,
                  ignition_key_input_in};
      sync2_r <= sync1_r;
   end

   ////////////////////////////////////////////////////////////////////
   // Registers and write decode
   logic [7:0] cfg_r; // Interval configuration
   logic [7:0] refresh_r; // Refresh control, temporary interval
   logic self_test_r; // Self-test mode
   logic [7:0] status_r; // Fault status
   logic [NUM_DRV-1:0] drv_sel_r; // 1 selects AND, 0 selects OR
   logic [NUM_DRV-1:0] drv_spi_r; // SPI on/off bits
   logic [NUM_DRV-1:0] ol_en_r; // Open-load pull-down enables

   wire logic wr_cfg = reg_req_in.we && reg_req_in.addr == ADDR_CFG;
   wire logic wr_ref = reg_req_in.we && reg_req_in.addr == ADDR_REFRESH;
   wire logic wr_ctl1 = reg_req_in.we && reg_req_in.addr == ADDR_CTRL1;
   wire logic wr_stat = reg_req_in.we && reg_req_in.addr == ADDR_STATUS;
   wire logic wr_sel = reg_req_in.we && reg_req_in.addr == ADDR_DRV_SEL;
   wire logic wr_on = reg_req_in.we && reg_req_in.addr == ADDR_DRV_ON;
   wire logic wr_ol = reg_req_in.we && reg_req_in.addr == ADDR_OL_EN;
   wire logic [7:0] wd = reg_req_in.data;

   ////////////////////////////////////////////////////////////////////
   // Tick prescaler and supervisor timer
   logic [PW-1:0] presc_r; // Cycle count within one ms
   logic [13:0] cnt_r; // Remaining ms
   logic [7:0] pulse_r; // Remaining reset pulse ms
   logic rst_drive_r; // Reset line being pulled low

   wire logic tick = presc_r == TICK_LAST;
   wire logic wd_run = cfg_r[CFG_EN_BIT] && !rst_drive_r;
   wire logic timeout = tick && wd_run && cnt_r <= 14'h0001;
   // Refresh is ignored while the reset pulse holds the defaults
   wire logic refresh = wr_ref && wd[REFRESH_BIT] && !timeout &&
                        !rst_drive_r;
   // Temporary value wins when nonzero, written or already stored
   wire logic [6:0] tmp_code = (wd[6:0] != 7'h00) ? wd[6:0] : refresh_r[6:0];
   wire logic [6:0] load_code = (tmp_code != 7'h00) ? tmp_code :
                                cfg_r[6:0];
   wire logic [13:0] load_val = interval_ms(load_code);
   wire logic [13:0] dflt_val = interval_ms(CFG_RST[6:0]);
   wire logic pulse_end = tick && rst_drive_r && pulse_r <= 8'h01;

   // Timer next value: timeout and pulse reload default, refresh reloads
   wire logic [13:0] cnt_nxt =
      (timeout || rst_drive_r) ? dflt_val :
      refresh ? load_val :
      !cfg_r[CFG_EN_BIT] ? interval_ms(cfg_r[6:0]) :
      tick ? cnt_r - 14'h0001 : cnt_r;
   wire logic [7:0] pulse_nxt = timeout ? PULSE_LEN :
      (tick && rst_drive_r && pulse_r != 8'h00) ? pulse_r - 8'h01 : pulse_r;
   wire logic rst_drive_nxt = timeout ? 1'b1 :
                              pulse_end ? 1'b0 : rst_drive_r;

   // Prescaler, timer and pulse state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         presc_r <= '0;
         cnt_r <= dflt_val;
         pulse_r <= PULSE_LEN;
         rst_drive_r <= 1'b1; // Power-on pulse
      end else begin
         presc_r <= tick ? '0 : presc_r + 1'b1;
         cnt_r <= cnt_nxt;
         pulse_r <= pulse_nxt;
         rst_drive_r <= rst_drive_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration, refresh control and self-test bit
   wire logic st_exit = wr_ctl1 && self_test_r && !wd[SELF_TEST_BIT];
   wire logic [7:0] cfg_nxt = timeout ? CFG_RST :
                              wr_cfg ? wd : cfg_r;
   // Loaded contents clear; a non-refresh write parks a temporary value
   wire logic [7:0] refresh_nxt =
      (timeout || rst_drive_r || refresh) ? REFRESH_RST :
      wr_ref ? {1'b0, wd[6:0]} : refresh_r;
   wire logic self_test_nxt = timeout ? 1'b0 :
                              wr_ctl1 ? wd[SELF_TEST_BIT] : self_test_r;

   // Status: self-test stores writes, else clear-only with set winning
   wire logic [7:0] stat_norm = (wr_stat ? (status_r & wd) : status_r)
                                | fault_s;
   wire logic [7:0] status_nxt =
      (st_exit || (timeout && self_test_r)) ? STATUS_RST :
      self_test_r ? (wr_stat ? wd : status_r) :
      stat_norm;

   // Register file state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cfg_r <= CFG_RST;
         refresh_r <= REFRESH_RST;
         self_test_r <= 1'b0;
         status_r <= STATUS_RST;
         drv_sel_r <= DRV_SEL_RST[NUM_DRV-1:0];
         drv_spi_r <= DRV_ON_RST[NUM_DRV-1:0];
         ol_en_r <= OL_EN_RST[NUM_DRV-1:0];
      end else begin
         cfg_r <= cfg_nxt;
         refresh_r <= refresh_nxt;
         self_test_r <= self_test_nxt;
         status_r <= status_nxt;
         drv_sel_r <= wr_sel ? wd[NUM_DRV-1:0] : drv_sel_r;
         drv_spi_r <= wr_on ? wd[NUM_DRV-1:0] : drv_spi_r;
         ol_en_r <= wr_ol ? wd[NUM_DRV-1:0] : ol_en_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Driver gating
   localparam logic [NUM_DRV-1:0] RELAY_MASK = NUM_DRV'(1) << RELAY_IDX;
   // Line low from us or from outside blocks everything
   wire logic rst_block = rst_drive_r || !rst_pin_s;
   wire logic [NUM_DRV-1:0] combined = (drv_sel_r & pin_s & drv_spi_r) |
      (~drv_sel_r & (pin_s | drv_spi_r));
   wire logic [NUM_DRV-1:0] key_mask = key_s ? '1 : RELAY_MASK;
   wire logic [NUM_DRV-1:0] drv_nxt = rst_block ? '0 : (combined & key_mask);

   // Read data selection, unused bits read zero
   wire logic [7:0] drv_sel_rd = 8'(drv_sel_r);
   wire logic [7:0] drv_spi_rd = 8'(drv_spi_r);
   wire logic [7:0] ol_en_rd = 8'(ol_en_r);
   wire logic [7:0] rd_nxt =
      (reg_rd_addr_in == ADDR_CFG) ? cfg_r :
      (reg_rd_addr_in == ADDR_REFRESH) ? refresh_r :
      (reg_rd_addr_in == ADDR_CTRL1) ? {1'b0, self_test_r, 6'h00} :
      (reg_rd_addr_in == ADDR_STATUS) ? status_r :
      (reg_rd_addr_in == ADDR_DRV_SEL) ? drv_sel_rd :
      (reg_rd_addr_in == ADDR_DRV_ON) ? drv_spi_rd :
      (reg_rd_addr_in == ADDR_OL_EN) ? ol_en_rd : 8'h00;

   // Output flops; open drain data is always low, enable does the work
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         low_side_driver_on_out <= '0;
         ol_pulldown_en_out <= OL_EN_RST[NUM_DRV-1:0];
         mcu_reset_output_out <= 1'b0;
         mcu_reset_output_oe_n_out <= 1'b0;
         rd_data_out <= 8'h00;
      end else begin
         low_side_driver_on_out <= drv_nxt;
         ol_pulldown_en_out <= ol_en_r;
         mcu_reset_output_out <= 1'b0;
         mcu_reset_output_oe_n_out <= !rst_drive_nxt;
         rd_data_out <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   refresh_reload_a: assert property (
      refresh |=> cnt_r == $past(load_val))
      else $error("refresh did not reload timer");
   ctl_clear_a: assert property (
      refresh |=> refresh_r == 8'h00)
      else $error("refresh control not cleared");
   timeout_pulse_a: assert property (
      timeout |=> rst_drive_r ##0 !mcu_reset_output_oe_n_out)
      else $error("timeout gave no reset pulse");
   selftest_store_a: assert property (
      self_test_r && wr_stat && !timeout && !wr_ctl1
      |=> status_r == $past(wd))
      else $error("self-test write not stored");
   clear_only_a: assert property (
      !self_test_r && wr_stat
      |=> (status_r & ~($past(wd & status_r) | $past(fault_s))) == 8'h00)
      else $error("host set a status bit");
   st_exit_a: assert property (
      st_exit && !timeout |=> status_r == STATUS_RST && !self_test_r)
      else $error("status not restored on self-test exit");
   wd_clears_a: assert property (
      timeout |=> !self_test_r && cfg_r == CFG_RST)
      else $error("timeout left self-test or config");
   st_isolate_a: assert property (
      self_test_r && !wr_stat && !wr_ctl1 && !timeout |=> $stable(status_r))
      else $error("status changed during self-test");
   key_gate_a: assert property (
      !key_s |=> (low_side_driver_on_out & ~RELAY_MASK) == '0)
      else $error("driver on with key low");
   rst_gate_a: assert property (
      rst_block |=> low_side_driver_on_out == '0)
      else $error("driver on during reset");

   timeout_c: cover property (timeout);
   temp_refresh_c: cover property (refresh && tmp_code != 7'h00);
   st_exit_c: cover property (st_exit);
   relay_key_off_c: cover property (!key_s && low_side_driver_on_out != '0);
endmodule // mcu_supervisor_watchdog
`default_nettype wire

/* core/supervisor_pkg.sv */
// Constants, register map and types for the MCU supervisor block.
// Assumes a 40 MHz core clock and an upstream serial decoder on that clock.
`default_nettype none
package supervisor_pkg;
   // Clock and tick timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // Reset pulse length in ticks (no figure given, plain default)
   localparam int RST_PULSE_MS = 10;
   // Driver count and index of the power relay output
   localparam int NUM_DRV = 6;
   localparam int RELAY_IDX = 5;
   // Register indices on the register port
   localparam logic [2:0] ADDR_CFG = 3'h0;
   localparam logic [2:0] ADDR_REFRESH = 3'h1;
   localparam logic [2:0] ADDR_CTRL1 = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;
   localparam logic [2:0] ADDR_DRV_SEL = 3'h4;
   localparam logic [2:0] ADDR_DRV_ON = 3'h5;
   localparam logic [2:0] ADDR_OL_EN = 3'h6;
   // Field positions
   localparam int CFG_EN_BIT = 7;
   localparam int MUL_S_BIT = 6;
   localparam int MUL_100_BIT = 5;
   localparam int MUL_10_BIT = 4;
   localparam int REFRESH_BIT = 7;
   localparam int SELF_TEST_BIT = 6;
   // Reset values
   localparam logic [7:0] CFG_RST = 8'hca;
   localparam logic [7:0] REFRESH_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] DRV_SEL_RST = 8'h00;
   localparam logic [7:0] DRV_ON_RST = 8'h00;
   localparam logic [7:0] OL_EN_RST = 8'h3f;
   // Multiplier weights in ms
   localparam logic [13:0] MUL_S_MS = 14'h03e8;
   localparam logic [13:0] MUL_100_MS = 14'h0064;
   localparam logic [13:0] MUL_10_MS = 14'h000a;
   localparam logic [13:0] MUL_1_MS = 14'h0001;
   localparam logic [3:0] MANT_MIN = 4'h1;
   localparam logic [3:0] MANT_MAX = 4'ha;

   // One register write request from the serial decoder
   typedef struct packed {
      logic we;
      logic [2:0] addr;
      logic [7:0] data;
   } reg_req_t;

   // Interval code to milliseconds
   function automatic logic [13:0] interval_ms(input logic [6:0] code);
      logic [3:0] m;
      logic [13:0] mul;
      m = (code[3:0] == 4'h0) ? MANT_MIN :
          (code[3:0] > MANT_MAX) ? MANT_MAX : code[3:0];
      mul = code[MUL_S_BIT] ? MUL_S_MS :
            code[MUL_100_BIT] ? MUL_100_MS :
            code[MUL_10_BIT] ? MUL_10_MS : MUL_1_MS;
      return 14'(m * mul);
   endfunction
endpackage
`default_nettype wire

/* test/host_mcu_model.sv */
// Host side of the open-drain reset line: pull-up, optional external pull.
// Assumes the block drives data 0 and releases the line with oe_n high.
`timescale 1ns/1ps
`default_nettype none

module host_mcu_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Open-drain line from the block
   input wire logic oe_n_in,
   input wire logic data_in,
   // Bench command: hold the line low from the host side
   input wire logic pull_low_in,
   // Resolved line and count of falling edges
   output logic line_out,
   output logic [7:0] pulses_out
);
   logic line_d_r; // Line level one edge ago

   ////////////////////////////////////////////////////////////////////////
   // Wired-AND with a pull-up: released line reads high, never stale
   assign line_out = ((!oe_n_in && !data_in) || pull_low_in) ? 1'b0 : 1'b1;

   // Count every fall, so a stray pulse is seen as well
   always_ff @(posedge mclk_in) begin
      line_d_r <= line_out;
      if (rst_in) begin
         pulses_out <= 8'h00;
      end else if (line_d_r && !line_out) begin
         pulses_out <= pulses_out + 8'h01;
      end
   end
endmodule // host_mcu_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the supervisor, status and driver gating.
// Assumes short tick and pulse parameters; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import supervisor_pkg::*;
   localparam int TK = 10; // Cycles per tick, shortened for run time
   localparam int PL = 2; // Reset pulse length in ticks
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   reg_req_t req = '0;
   logic [2:0] rd_addr = 3'h0;
   logic [7:0] rd_data, rv, fault = 8'h00, pulses;
   logic key = 1'b1, ext_pull = 1'b0, rst_data, oe_n;
   logic [5:0] pins = 6'h00, drv_on, ol_en, s, o;
   wire logic line;
   int n_errors = 0, comparisons = 0, seed = 32'hce3a, i, p0;

   ////////////////////////////////////////////////////////////////////////
   // Clock and instances
   initial forever #12.5 mclk_in = ~mclk_in;

   mcu_supervisor_watchdog #(.TICK_CYC(TK), .RST_PULSE_MS(PL)) dut_u (
      .mclk_in(mclk_in), .rst_in(rst_in), .reg_req_in(req),
      .reg_rd_addr_in(rd_addr), .rd_data_out(rd_data),
      .ignition_key_input_in(key), .drv_pin_in(pins), .fault_in(fault),
      .mcu_reset_output_in(line), .mcu_reset_output_out(rst_data),
      .mcu_reset_output_oe_n_out(oe_n), .low_side_driver_on_out(drv_on),
      .ol_pulldown_en_out(ol_en));
   host_mcu_model host_u (.mclk_in(mclk_in), .rst_in(rst_in),
      .oe_n_in(oe_n), .data_in(rst_data), .pull_low_in(ext_pull),
      .line_out(line), .pulses_out(pulses));

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin // Four-state compare, unknown matches only unknown
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask

   // One-cycle write strobe, then a quiet edge before the next one
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk_in) req = {1'b1, a, d};
      @(negedge mclk_in) req.we = 1'b0;
   endtask

   // Read data is registered: present address, sample one cycle on
   task automatic rchk(input string what, input logic [2:0] a,
                       input logic [7:0] e);
      @(negedge mclk_in) rd_addr = a;
      @(negedge mclk_in) chk(what, e, rd_data);
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge mclk_in);
   endtask

   // Bounded wait on the reset line level
   task automatic wait_line(input logic lvl);
      for (int k = 0; k < 2000 && line !== lvl; k++) @(negedge mclk_in);
      if (line !== lvl) begin
         chk("reset line level", {7'h0, lvl}, {7'h0, line});
         end_sim;
      end
   endtask

   // Interval code to milliseconds, worked out independently
   function automatic int exp_ms(input logic [6:0] c);
      int m, mul;
      m = (c[3:0] == 4'h0) ? 1 : (c[3:0] > 4'ha) ? 10 : int'(c[3:0]);
      mul = c[6] ? 1000 : c[5] ? 100 : c[4] ? 10 : 1;
      return m * mul;
   endfunction

   function automatic logic [5:0] exp_drv(input logic k,
      input logic [5:0] p, input logic [5:0] sl, input logic [5:0] on);
      logic [5:0] v;
      v = (sl & p & on) | (~sl & (p | on)); // Select 1 means AND
      if (!k) v = v & 6'h20; // Only the relay survives key low
      return v;
   endfunction

   // Program, refresh, time the interval to the pulse, then check the defaults it leaves
   task automatic timeout_case(input logic [7:0] cfg, input logic [7:0] refr);
      int n, ms;
      ms = exp_ms((refr[6:0] != 7'h0) ? refr[6:0] : cfg[6:0]);
      wr(ADDR_CFG, cfg);
      p0 = pulses;
      wr(ADDR_REFRESH, refr);
      n = 1;
      for (; n < 12000 && line === 1'b1; n++) @(negedge mclk_in);
      comparisons++;
      if (n < (ms - 1) * TK || n > ms * TK + 3) begin
         n_errors++;
         $display("unexpected timeout cycles expected %0d seen %0d",
                  ms * TK, n);
      end
      settle(3);
      chk("drivers in pulse", 8'h00, {2'h0, drv_on});
      chk("pulse count", 8'(p0 + 1), pulses);
      wait_line(1'b1);
      rchk("cfg after pulse", ADDR_CFG, CFG_RST);
      rchk("self-test after pulse", ADDR_CTRL1, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      settle(2);
      rst_in = 1'b0;
      settle(1);
      chk("line after reset", 8'h00, {7'h0, line});
      chk("drivers after reset", 8'h00, {2'h0, drv_on});
      chk("open-load enables", 8'h3f, {2'h0, ol_en});
      wait_line(1'b1);
      rchk("cfg default", ADDR_CFG, 8'hca);
      rchk("refresh default", ADDR_REFRESH, 8'h00);
      rchk("status default", ADDR_STATUS, 8'h00);
      rchk("ctrl1 default", ADDR_CTRL1, 8'h00);
      rchk("unmapped read", 3'h7, 8'h00);
      // Driver combining, random with corners first
      for (i = 0; i < 10; i++) begin
         s = (i == 0) ? 6'h3f : 6'($random(seed));
         o = (i < 2) ? 6'h3f : 6'($random(seed));
         wr(ADDR_DRV_SEL, {2'h0, s});
         wr(ADDR_DRV_ON, {2'h0, o});
         @(negedge mclk_in) pins = 6'($random(seed));
         key = (i == 1) ? 1'b0 : 1'($random(seed));
         settle(5);
         chk("driver outputs", {2'h0, exp_drv(key, pins, s, o)},
             {2'h0, drv_on});
      end
      key = 1'b1;
      ext_pull = 1'b1; // Host holds the line low itself
      settle(5);
      chk("drivers, line held", 8'h00, {2'h0, drv_on});
      ext_pull = 1'b0;
      wait_line(1'b1);
      // Status: faults set, host only clears
      rv = 8'($random(seed));
      fault = rv;
      settle(5);
      fault = 8'h00;
      settle(3);
      rchk("status from faults", ADDR_STATUS, rv);
      wr(ADDR_STATUS, 8'h0f);
      wr(ADDR_STATUS, 8'hff);
      rchk("status after clears", ADDR_STATUS, rv & 8'h0f);
      // Self-test kept far shorter than the default interval
      wr(ADDR_CTRL1, 8'h40);
      fault = 8'hff;
      wr(ADDR_STATUS, 8'h5a);
      rchk("self-test write", ADDR_STATUS, 8'h5a);
      wr(ADDR_STATUS, 8'ha5);
      rchk("self-test rewrite", ADDR_STATUS, 8'ha5);
      fault = 8'h00;
      settle(4);
      wr(ADDR_CTRL1, 8'h00);
      rchk("status on exit", ADDR_STATUS, STATUS_RST);
      // Regular refresh keeps the line high
      wr(ADDR_CFG, 8'h85);
      p0 = pulses;
      repeat (6) begin
         wr(ADDR_REFRESH, 8'h80);
         settle(30);
      end
      chk("pulses while refreshed", 8'(p0), pulses);
      wr(ADDR_CFG, 8'h01);
      wr(ADDR_REFRESH, 8'h80);
      settle(100);
      chk("pulses while disabled", 8'(p0), pulses);
      // Self-test cut short by a timeout
      wr(ADDR_CTRL1, 8'h40);
      wr(ADDR_STATUS, 8'h33);
      timeout_case(8'h81, 8'h80);
      rchk("status after pulse", ADDR_STATUS, 8'h00);
      // Interval codes: zero, overflow, x10, two multipliers
      timeout_case(8'h80, 8'h80);
      timeout_case(8'h8f, 8'h80);
      timeout_case(8'h93, 8'h80);
      timeout_case(8'hb2, 8'h80);
      for (i = 0; i < 3; i++) begin
         timeout_case(8'h80 | (8'($random(seed)) & 8'h1f), 8'h80);
      end
      // Control register reads zero after a plain refresh, then a one-shot interval
      wr(ADDR_CFG, 8'h85);
      wr(ADDR_REFRESH, 8'h80);
      rchk("refresh after load", ADDR_REFRESH, 8'h00);
      timeout_case(8'h85, 8'h82);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
